/* File: src/tmos_timer_top.sv */
// Purpose: Timer/event counter with two compare registers and one-shot output.
// Assumes: Trigger pin is asynchronous; software keeps to the documented order.
// Notes: The count clock is a prescaler tick derived from clk.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tmos_timer_top #(
   parameter int unsigned CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write channels
   input wire logic [tmos_pkg::TMOS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [tmos_pkg::TMOS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic trigger_input_a,
   output logic pulse_out,
   output logic irq
);
   import tmos_pkg::*;

   tmos_reg_if rif ();

   tmos_axi_slave u_slave (
      .clk(clk),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rif(rif.slave)
   );

   localparam logic [CNT_W-1:0] CNT_ONES = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

   logic [3:0] timer_mode_control_reg;
   logic [5:0] prescaler_mode_reg;
   logic [CNT_W-1:0] main_counter_reg;
   logic [CNT_W-1:0] capture_compare_a_reg;
   logic [CNT_W-1:0] capture_compare_b_reg;
   logic [TMOS_ST_W-1:0] status_reg;
   logic [TMOS_ST_W-1:0] status_next;
   logic [TMOS_ST_W-1:0] mask_reg;
   logic [TMOS_PRESC_W-1:0] div_cnt_reg;
   logic [TMOS_PRESC_W-1:0] div_mask;
   logic trig_meta_reg;
   logic trig_sync_reg;
   logic trig_prev_reg;
   logic osp_active_reg;
   logic zero_hold_reg;
   logic [1:0] run_mode;
   logic [1:0] edge_sel;
   logic [1:0] presc_sel;
   logic running;
   logic osp_en;
   logic tick;
   logic ext_edge;
   logic sw_trig;
   logic trig_accept;
   logic edge_clear;
   logic trig_clear;
   logic match_a_ev;
   logic match_b_ev;
   logic ovf_ev;
   logic [TMOS_ST_W-1:0] status_set;
   logic [TMOS_ST_W-1:0] status_clr;

   function automatic logic reg_wr(input logic [7:0] ofs);
      return rif.wr_en && (rif.wr_addr == ofs);
   endfunction

   function automatic logic [31:0] wr_merge(input logic [31:0] old_v);
      return apply_strb(old_v, rif.wr_data, rif.wr_strb);
   endfunction

   assign run_mode = timer_mode_control_reg[MODE_RUN_LSB +: 2];
   assign osp_en = timer_mode_control_reg[MODE_OSP_BIT];
   assign edge_sel = prescaler_mode_reg[PRESC_EDGE_LSB +: 2];
   assign presc_sel = prescaler_mode_reg[PRESC_SEL_LSB +: 2];
   assign running = (run_mode != RUN_STOP);

   // Register writes. Edge select is taken at any time; changing it while
   // running can fake an edge, which is why software stops the timer first.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_mode_control_reg <= RST_MODE;
         prescaler_mode_reg <= RST_PRESC;
         capture_compare_a_reg <= CNT_W'(RST_CC);
         capture_compare_b_reg <= CNT_W'(RST_CC);
         mask_reg <= RST_MASK;
      end else begin
         if (reg_wr(OFS_MODE)) begin
            timer_mode_control_reg <= 4'(wr_merge({28'h0, timer_mode_control_reg}));
         end
         if (reg_wr(OFS_PRESC)) begin
            prescaler_mode_reg <= 6'(wr_merge({26'h0, prescaler_mode_reg}));
         end
         // Compare values survive a stop here, but software may not count on it.
         if (reg_wr(OFS_CCA)) begin
            capture_compare_a_reg <= CNT_W'(wr_merge(32'(capture_compare_a_reg)));
         end
         if (reg_wr(OFS_CCB)) begin
            capture_compare_b_reg <= CNT_W'(wr_merge(32'(capture_compare_b_reg)));
         end
         if (reg_wr(OFS_MASK)) begin
            mask_reg <= TMOS_ST_W'(wr_merge({29'h0, mask_reg}));
         end
      end
   end

   // The helpers read the write bus directly. A process follows what they read,
   // while a continuous assignment would only follow their arguments.
   always_comb begin
      sw_trig = reg_wr(OFS_TRIG) && rif.wr_strb[0] && rif.wr_data[TRIG_SW_BIT];
      status_clr = '0;
      if (reg_wr(OFS_STATUS)) begin
         status_clr = TMOS_ST_W'(wr_merge(32'h0));
      end
   end

   always_comb begin
      case (rif.rd_addr)
         OFS_MODE: rif.rd_data = {28'h0, timer_mode_control_reg};
         OFS_PRESC: rif.rd_data = {26'h0, prescaler_mode_reg};
         OFS_COUNT: rif.rd_data = 32'(main_counter_reg);
         OFS_CCA: rif.rd_data = 32'(capture_compare_a_reg);
         OFS_CCB: rif.rd_data = 32'(capture_compare_b_reg);
         OFS_STATUS: rif.rd_data = {29'h0, status_reg};
         OFS_MASK: rif.rd_data = {29'h0, mask_reg};
         default: rif.rd_data = 32'h0000_0000;
      endcase
   end

   // The prescaler runs free and is never restarted by a start, so the first
   // tick after start comes anywhere within one count period.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 1'b1;
      end
   end

   always_comb begin
      case (presc_sel)
         2'h0: div_mask = DIV_MASK_0;
         2'h1: div_mask = DIV_MASK_1;
         2'h2: div_mask = DIV_MASK_2;
         default: div_mask = DIV_MASK_3;
      endcase
   end

   assign tick = ((div_cnt_reg & div_mask) == div_mask);

   // Trigger pin synchroniser. The previous-value flop resets low, so a pin
   // held high out of reset shows one rising edge in the second cycle after reset, whether the timer runs or not.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_meta_reg <= trigger_input_a;
         trig_sync_reg <= trig_meta_reg;
         trig_prev_reg <= trig_sync_reg;
      end
   end

   always_comb begin
      case (edge_sel)
         EDGE_FALL: ext_edge = !trig_sync_reg && trig_prev_reg;
         EDGE_RISE: ext_edge = trig_sync_reg && !trig_prev_reg;
         EDGE_BOTH: ext_edge = trig_sync_reg != trig_prev_reg;
         default: ext_edge = 1'b0;
      endcase
   end

   // The pin stays live in software-trigger one-shot use as well.
   assign trig_accept = running && osp_en && !osp_active_reg && (sw_trig || ext_edge);
   assign edge_clear = running && (run_mode == RUN_EDGE_CLR) && ext_edge && !osp_active_reg;
   assign trig_clear = trig_accept || edge_clear;

   assign match_a_ev = running && tick && !trig_clear && (main_counter_reg == capture_compare_a_reg);
   assign match_b_ev = running && tick && !trig_clear && (main_counter_reg == capture_compare_b_reg);
   assign ovf_ev = running && tick && !trig_clear && (main_counter_reg == CNT_ONES) &&
                   ((run_mode != RUN_MATCH_CLR) || (capture_compare_a_reg == CNT_ONES));

   always_ff @(posedge clk) begin
      if (sys_rst || !running) begin
         main_counter_reg <= CNT_ZERO;
      end else if (trig_clear) begin
         main_counter_reg <= CNT_ZERO;
      end else if (tick) begin
         if ((run_mode == RUN_MATCH_CLR) && (main_counter_reg == capture_compare_a_reg)) begin
            main_counter_reg <= CNT_ZERO;
         end else begin
            main_counter_reg <= main_counter_reg + 1'b1;
         end
      end
   end

   // Marks the count period in which the counter sits at zero after a wrap.
   always_ff @(posedge clk) begin
      if (sys_rst || !running || trig_clear) begin
         zero_hold_reg <= 1'b0;
      end else if (ovf_ev) begin
         zero_hold_reg <= 1'b1;
      end else if (tick) begin
         zero_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !running) begin
         osp_active_reg <= 1'b0;
         pulse_out <= 1'b0;
      end else if (trig_accept) begin
         osp_active_reg <= 1'b1;
         pulse_out <= 1'b0;
      end else if (osp_active_reg) begin
         if (match_a_ev) begin
            osp_active_reg <= 1'b0;
            pulse_out <= 1'b0;
         end else if (match_b_ev) begin
            pulse_out <= 1'b1;
         end
      end
   end

   // A set in the same cycle as a clear wins, and the zero-hold window keeps
   // re-setting overflow so an early clear is lost.
   always_comb begin
      status_set = '0;
      status_set[ST_OVF] = ovf_ev || zero_hold_reg;
      status_set[ST_MATCH_A] = match_a_ev;
      status_set[ST_MATCH_B] = match_b_ev;
      status_next = (status_reg & ~status_clr) | status_set;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_reg <= '0;
         irq <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq <= |(status_next & mask_reg);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   count_up_a: assert property (
      running && tick && !trig_clear && (run_mode == RUN_FREE) &&
      (main_counter_reg != CNT_ONES)
      |=> main_counter_reg == CNT_W'($past(main_counter_reg) + 1'b1))
      else $error("counter did not advance on a tick");

   start_count_a: assert property (
      running && !$past(running) && tick && !trig_clear && (run_mode != RUN_MATCH_CLR)
      |=> main_counter_reg == CNT_W'(1))
      else $error("counter did not start on the first tick after start");

   stop_hold_a: assert property (
      (run_mode == RUN_STOP) [*2] |-> (main_counter_reg == CNT_ZERO) && !pulse_out)
      else $error("stopped timer is not held at zero");

   start_free_a: assert property (
      $rose(running) |-> div_cnt_reg == TMOS_PRESC_W'($past(div_cnt_reg) + 1'b1))
      else $error("prescaler was restarted by a timer start");

   retrig_ignore_a: assert property (
      running && osp_active_reg && ext_edge && !match_a_ev && (main_counter_reg != CNT_ONES)
      |=> osp_active_reg &&
          ((main_counter_reg != CNT_ZERO) || ($past(main_counter_reg) == CNT_ZERO)))
      else $error("trigger edge disturbed a running pulse");

   ext_restart_a: assert property (
      running && osp_en && !osp_active_reg && ext_edge && !$changed(run_mode)
      |=> osp_active_reg && (main_counter_reg == CNT_ZERO))
      else $error("external edge did not restart the one-shot");

   ovf_set_a: assert property (
      ovf_ev |=> status_reg[ST_OVF] && (main_counter_reg == CNT_ZERO))
      else $error("wrap to zero did not set overflow");

   ovf_reclear_a: assert property (
      zero_hold_reg && !tick && !trig_clear && running |=> status_reg[ST_OVF] && zero_hold_reg)
      else $error("overflow not held while the counter sits at zero");

   pulse_end_a: assert property (
      running && osp_active_reg && match_a_ev && !$changed(run_mode)
      |=> !osp_active_reg && !pulse_out)
      else $error("one-shot did not end on match a");

   irq_level_a: assert property (
      (|(status_reg & mask_reg)) [*2] |-> irq)
      else $error("interrupt low with an unmasked status bit set");

   pulse_start_a: assert property (
      running && osp_active_reg && match_b_ev && !match_a_ev |=> pulse_out)
      else $error("one-shot did not start on match b");

   soft_start_a: assert property (
      running && osp_en && !osp_active_reg && sw_trig
      |=> osp_active_reg && (main_counter_reg == CNT_ZERO))
      else $error("software trigger did not start the one-shot");

   edge_clear_a: assert property (
      running && (run_mode == RUN_EDGE_CLR) && !osp_active_reg && ext_edge
      |=> main_counter_reg == CNT_ZERO)
      else $error("valid edge did not clear the counter");

   ovf_clear_lost_a: assert property (
      zero_hold_reg && status_clr[ST_OVF] |=> status_reg[ST_OVF])
      else $error("overflow clear took effect while counter was zero");
endmodule
`default_nettype wire

/* File: common/tmos_pkg.sv */
// Purpose: Shared constants, encodings and helpers of the one-shot timer block.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes: Offsets are byte addresses on the register bus.
//
// Functional notes
// - Counter runs at once on non-stop mode.
// - Trigger edges during a pulse are ignored.
// - Start-to-match delay varies up to one tick.
// - Compare contents are not guaranteed after stop.
// - External edge restarts counter in software mode.
// - Overflow flag sets on wrap to zero.
// - Clearing overflow while counter zero is overridden.
package tmos_pkg;

   localparam int unsigned TMOS_ADDR_W = 8;
   localparam int unsigned TMOS_PRESC_W = 8;
   localparam int unsigned TMOS_ST_W = 3;

   // Register byte offsets.
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_PRESC = 8'h04;
   localparam logic [7:0] OFS_TRIG = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0c;
   localparam logic [7:0] OFS_CCA = 8'h10;
   localparam logic [7:0] OFS_CCB = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1c;

   // Field positions.
   localparam int unsigned MODE_OSP_BIT = 1;
   localparam int unsigned MODE_RUN_LSB = 2;
   localparam int unsigned PRESC_SEL_LSB = 0;
   localparam int unsigned PRESC_EDGE_LSB = 4;
   localparam int unsigned TRIG_SW_BIT = 0;
   localparam int unsigned ST_OVF = 0;
   localparam int unsigned ST_MATCH_A = 1;
   localparam int unsigned ST_MATCH_B = 2;

   // Values after reset.
   localparam logic [3:0] RST_MODE = 4'h0;
   localparam logic [5:0] RST_PRESC = 6'h00;
   localparam logic [15:0] RST_CC = 16'hffff;
   localparam logic [2:0] RST_MASK = 3'h0;

   // Run-mode encodings of the two-bit run field.
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_FREE = 2'h1;
   localparam logic [1:0] RUN_EDGE_CLR = 2'h2;
   localparam logic [1:0] RUN_MATCH_CLR = 2'h3;

   // Valid-edge encodings of the trigger input.
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Prescaler tick masks, divide by 1, 2, 16 and 256.
   localparam logic [7:0] DIV_MASK_0 = 8'h00;
   localparam logic [7:0] DIV_MASK_1 = 8'h01;
   localparam logic [7:0] DIV_MASK_2 = 8'h0f;
   localparam logic [7:0] DIV_MASK_3 = 8'hff;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= OFS_MASK);
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

endpackage

/* File: common/tmos_reg_if.sv */
// Purpose: Register access path between the bus slave and the timer core.
// Assumes: One clock domain; write strobe is a one-cycle pulse.
// Notes: Read data is combinational from the core for the given address.
`timescale 1ns/1ns
`default_nettype none
interface tmos_reg_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb,
                  output rd_addr, input rd_data);
   modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                 input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: src/tmos_axi_slave.sv */
// Purpose: AXI4-Lite slave that turns bus transfers into register accesses.
// Assumes: One write and one read outstanding at most.
// Notes: Unmapped or misaligned addresses answer SLVERR and read as zero.
`timescale 1ns/1ns
`default_nettype none
module tmos_axi_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Write channels
   input wire logic [tmos_pkg::TMOS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [tmos_pkg::TMOS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side
   tmos_reg_if.slave rif
);
   import tmos_pkg::*;

   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;

   // Address and data are held until both have arrived, in either order.
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign rif.wr_en = wr_fire && addr_mapped(aw_addr_reg);
   assign rif.wr_addr = aw_addr_reg;
   assign rif.wr_data = w_data_reg;
   assign rif.wr_strb = w_strb_reg;
   assign rif.rd_addr = s_axi_araddr;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= addr_mapped(s_axi_araddr) ? rif.rd_data : 32'h0000_0000;
            s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/tmos_pin_model.sv */
// Purpose: Drives the trigger pin as an external trigger source would.
// Assumes: Each toggle of req asks for one high pulse on the pin.
// Notes: The pin idles low, so only the requested pulses make edges.
`timescale 1ns/1ns
`default_nettype none
module tmos_pin_model #(
   parameter int HOLD = 4
) (
   // Clock
   input wire logic clk,
   // Request and pin
   input wire logic req,
   output logic trigger_input_a
);
   logic req_q;
   int cnt;
   initial begin
      req_q = 1'b0;
      cnt = 0;
      trigger_input_a = 1'b0;
   end
   always @(posedge clk) begin
      req_q <= req;
      if (req != req_q) begin
         cnt <= HOLD;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      trigger_input_a <= (req != req_q) || (cnt > 1);
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the one-shot timer over its register bus.
// Assumes: Divide by one unless a test changes it; trigger pin idles low.
// Notes: The overflow test walks the whole count range and takes most of the run.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import tmos_pkg::*;
   logic clk, sys_rst, awv, wv, bre, arv, rre, pin_req, pin;
   logic awr, wr_rdy, bv, arr, rv, pls, irq;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, v;
   logic [1:0] brsp, rrsp, rsp;
   logic [3:0] ws;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int w, n;
   logic [7:0] ofs [8] = '{OFS_MODE, OFS_PRESC, OFS_TRIG, OFS_COUNT,
                           OFS_CCA, OFS_CCB, OFS_STATUS, OFS_MASK};
   logic [31:0] exv [8] = '{32'h0, 32'h0, 32'h0, 32'h0,
                            {16'h0, RST_CC}, {16'h0, RST_CC}, 32'h0, 32'h0};

   tmos_timer_top u_tmos_timer_top (
      .clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
      .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .trigger_input_a(pin), .pulse_out(pls), .irq(irq)
   );
   tmos_pin_model u_tmos_pin_model (.clk(clk), .req(pin_req), .trigger_input_a(pin));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, s, e);
      end
   endtask

   // Address and data are offered together; each is dropped once taken.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (awv && awr) ad = 1'b1;
         if (wv && wr_rdy) dd = 1'b1;
         awv <= awv && !awr;
         wv <= wv && !wr_rdy;
      end
      while (!bv) @(posedge clk);
      rsp = brsp;
      bre <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      @(posedge clk);
      while (!arr) @(posedge clk);
      arv <= 1'b0;
      @(posedge clk);
      while (!rv) @(posedge clk);
      d = rdat;
      rsp = rrsp;
      rre <= 1'b0;
      @(posedge clk);
   endtask

   // Counts the cycles of the next pulse; refire makes a pin edge mid-pulse.
   task automatic pw(input logic refire, output int wd_c);
      n = 0;
      wd_c = 0;
      while (!pls && n < 400) begin
         @(posedge clk);
         n++;
      end
      while (pls && wd_c < 400) begin
         if (refire && wd_c == 8) pin_req <= ~pin_req;
         @(posedge clk);
         wd_c++;
      end
   endtask

   initial begin
      sys_rst = 1'b1;
      {awv, wv, bre, arv, rre, pin_req, awa, ara, wd} = '0;
      ws = 4'hf;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      foreach (ofs[i]) begin
         rd_reg(ofs[i], v);
         chk(v, exv[i], "reset value");
      end
      rd_reg(8'h20, v);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
      wr_reg(8'h22, 32'h1);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
      $display("test registers done");
      wr_reg(OFS_PRESC, 32'h10);
      wr_reg(OFS_CCB, 32'h10);
      wr_reg(OFS_CCA, 32'h40);
      wr_reg(OFS_MODE, 32'h6);
      rd_reg(OFS_COUNT, v);
      chk({31'h0, v != 32'h0}, 32'h1, "count runs");
      wr_reg(OFS_TRIG, 32'h1);
      pw(1'b0, w);
      chk(w, 32'h30, "soft pulse width");
      wr_reg(OFS_STATUS, 32'h7);
      rd_reg(OFS_STATUS, v);
      chk(v, 32'h0, "status cleared");
      pin_req <= ~pin_req;
      pw(1'b0, w);
      chk(w, 32'h30, "pin pulse in soft mode");
      rd_reg(OFS_STATUS, v);
      chk(v, 32'h6, "match flags");
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr_reg(OFS_MASK, 32'h2);
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      wr_reg(OFS_STATUS, 32'h2);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test soft one-shot done");
      wr_reg(OFS_MODE, 32'h0);
      wr_reg(OFS_PRESC, 32'h10);
      wr_reg(OFS_MODE, 32'ha);
      pin_req <= ~pin_req;
      pw(1'b1, w);
      chk(w, 32'h30, "retrigger ignored");
      $display("test pin one-shot done");
      wr_reg(OFS_MODE, 32'h0);
      wr_reg(OFS_PRESC, 32'h0);
      wr_reg(OFS_MODE, 32'h8);
      repeat (100) @(posedge clk);
      pin_req <= ~pin_req;
      repeat (10) @(posedge clk);
      rd_reg(OFS_COUNT, v);
      chk({31'h0, v < 32'h4}, 32'h1, "falling edge clears count");
      wr_reg(OFS_MODE, 32'h0);
      wr_reg(OFS_PRESC, 32'h10);
      $display("test edge clear done");
      wr_reg(OFS_MODE, 32'h0);
      wr_reg(OFS_CCA, 32'h20);
      wr_reg(OFS_MODE, 32'hc);
      repeat (50) @(posedge clk);
      rd_reg(OFS_COUNT, v);
      chk({31'h0, v <= 32'h20}, 32'h1, "match clear bound");
      wr_reg(OFS_MODE, 32'h0);
      rd_reg(OFS_COUNT, v);
      chk(v, 32'h0, "stopped count");
      $display("test match clear done");
      wr_reg(OFS_STATUS, 32'h7);
      wr_reg(OFS_CCA, 32'hffff);
      wr_reg(OFS_MASK, 32'h1);
      wr_reg(OFS_MODE, 32'h4);
      n = 0;
      do begin
         rd_reg(OFS_COUNT, v);
         n++;
      end while (v < 32'hffe0 && n < 30000);
      // Slow the count near the top so the flag can be cleared while it sits at zero.
      wr_reg(OFS_PRESC, 32'h13);
      n = 0;
      while (!irq && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, irq}, 32'h1, "overflow irq");
      wr_reg(OFS_STATUS, 32'h1);
      rd_reg(OFS_STATUS, v);
      chk({31'h0, v[ST_OVF]}, 32'h1, "clear at zero");
      rd_reg(OFS_COUNT, v);
      chk(v, 32'h0, "wrapped to zero");
      repeat (260) @(posedge clk);
      wr_reg(OFS_STATUS, 32'h1);
      rd_reg(OFS_STATUS, v);
      chk({31'h0, v[ST_OVF]}, 32'h0, "clear after tick");
      chk({31'h0, irq}, 32'h0, "irq after clear");
      $display("test overflow done");
      wrap_up();
   end
endmodule
`default_nettype wire
